/* eeprom_program_erase_ctrl.sv */
// Contract
// - control register at 00f3; bit7 guard, bits6-5 zero, bits4-0 control fields.
// - guard set refuses whole-array and row erase; clear allows bulk erase.
// - guard writable only with hv_apply and protect_lock both zero.
// - wipe_config zero ignores extent bits, program/read; one selects erase.
// - single-location erase hits only latched address, byte or word by size.
// - latch_arm set makes array unreadable and arms address/data latches.
// - extent, wipe_config, latch_arm writable together or apart while hv_apply zero.
// - hv_apply sets only when latch_arm already set; both at once sets latch_arm only.
// - hv_apply set freezes guard, extent, wipe_config and latch_arm.
// - hv_apply set ignores array writes and freezes latched address and data.
// - hv_apply drives program/erase voltage; clearing removes it.
// - protect_lock blocks writes to block_guard and the guard bit.
// - set block_guard bit prevents program and erase of its block.
// - stop mode removes voltage, hv_apply kept; leaving stop restores it.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "eeprom_ctrl_consts.svh"

module eeprom_program_erase_ctrl (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [15:0] wb_dat_i,
    input wire logic [1:0] wb_sel_i,
    output logic [15:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic stop_req_pin,
    output logic hv_enable,
    output logic array_read_block,
    output logic erase_mode,
    output logic [1:0] erase_extent,
    output logic [15:0] prog_addr,
    output logic [15:0] prog_data,
    output logic prog_is_word,
    output logic prog_go
);
    eeprom_ctrl_pkg::prog_ctrl_s ctrl;
    eeprom_ctrl_pkg::latch_s lat;
    logic [`GUARD_WIDTH-1:0] block_guard;
    logic protect_lock;
    logic stop_sw;
    logic stop_pin;
    logic latched_blocked;

    stop_sync u_stop_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(stop_req_pin),
        .level(stop_pin)
    );

    guard_decode u_guard_decode (
        .addr(lat.addr),
        .block_guard(block_guard),
        .blocked(latched_blocked)
    );

    // bus decode; an odd address takes the low byte lane of the 16-bit bus, an even one the high lane
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i;
    wire [15:0] word_adr = {wb_adr_i[15:1], 1'b0};
    wire [7:0] wbyte = wb_adr_i[0] ? wb_dat_i[7:0] : wb_dat_i[15:8];
    wire hit_ctrl = wb_adr_i == `PROG_CTRL_ADDR;
    wire hit_guard = wb_adr_i == `GUARD_ADDR;
    wire hit_modcfg = wb_adr_i == `MODCFG_ADDR;
    wire hit_status = wb_adr_i == `STATUS_ADDR;
    wire hit_array = (wb_adr_i >= `ARRAY_BASE) && (wb_adr_i <= `ARRAY_LAST);
    wire hv_now = ctrl.hv_apply;

    wire ctrl_wr = wr && hit_ctrl;
    wire guard_ok = !hv_now && !protect_lock;
    wire [7:0] cur_ctrl = {ctrl.whole_wipe_guard, 2'b00, ctrl.single_loc_sel,
                           ctrl.page32_sel, ctrl.wipe_config, ctrl.latch_arm,
                           ctrl.hv_apply};

    // next control value
    eeprom_ctrl_pkg::prog_ctrl_s next_ctrl;
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_wr) begin
            if (guard_ok) begin
                next_ctrl.whole_wipe_guard = wbyte[`BIT_WIPE_GUARD];
            end
            if (!hv_now) begin
                next_ctrl.single_loc_sel = wbyte[`BIT_SINGLE_LOC];
                next_ctrl.page32_sel = wbyte[`BIT_PAGE32];
                next_ctrl.wipe_config = wbyte[`BIT_WIPE_CFG];
                next_ctrl.latch_arm = wbyte[`BIT_LATCH_ARM];
            end
            // voltage only once the latches were armed beforehand
            next_ctrl.hv_apply = wbyte[`BIT_HV_APPLY] && ctrl.latch_arm;
        end
    end

    // array write latched only while armed and not under voltage
    wire arr_wr = wr && hit_array && ctrl.latch_arm && !hv_now;
    wire is_word = (wb_sel_i == 2'h3) && !wb_adr_i[0];
    eeprom_ctrl_pkg::latch_s next_lat;
    always_comb begin
        next_lat = lat;
        if (arr_wr) begin
            next_lat.addr = is_word ? word_adr : wb_adr_i;
            next_lat.data = is_word ? wb_dat_i : {8'h00, wbyte};
            next_lat.is_word = is_word;
            next_lat.valid = 1'b1;
        end
        if (ctrl_wr && !hv_now && !wbyte[`BIT_LATCH_ARM]) begin
            next_lat.valid = 1'b0;
        end
    end

    // erase extent and refusal
    // decoded from the next value so extent lands on the same edge as wipe_config
    wire [1:0] extent_code = next_ctrl.single_loc_sel ? 2'(eeprom_ctrl_pkg::extent_single) :
                             next_ctrl.page32_sel ? 2'(eeprom_ctrl_pkg::extent_row) :
                             2'(eeprom_ctrl_pkg::extent_bulk);
    wire wide_erase = ctrl.wipe_config && !ctrl.single_loc_sel;
    wire guard_refuse = wide_erase && ctrl.whole_wipe_guard;
    // wide erase refused if any block is guarded; single hits only its block
    wire block_refuse = wide_erase ? (|block_guard) : latched_blocked;
    wire op_allowed = lat.valid && !guard_refuse && !block_refuse;
    wire stopped = stop_sw || stop_pin;

    // read mux
    logic [15:0] rd_word;
    wire [7:0] guard_rd = {3'h0, block_guard};
    wire [7:0] modcfg_rd = {6'h00, protect_lock, stop_sw};
    wire [7:0] status_rd = {5'h00, op_allowed, lat.valid, hv_enable};
    wire [7:0] rbyte = hit_ctrl ? cur_ctrl :
                       hit_guard ? guard_rd :
                       hit_modcfg ? modcfg_rd :
                       hit_status ? status_rd : 8'h00;
    assign rd_word = wb_adr_i[0] ? {8'h00, rbyte} : {rbyte, 8'h00};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl <= '0;
            lat <= '0;
            block_guard <= '0;
            protect_lock <= 1'b0;
            stop_sw <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 16'h0000;
        end else begin
            ctrl <= next_ctrl;
            lat <= next_lat;
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? rd_word : 16'h0000;
            if (wr && hit_guard && guard_ok) begin
                block_guard <= wbyte[`GUARD_WIDTH-1:0];
            end
            if (wr && hit_modcfg) begin
                protect_lock <= wbyte[`BIT_PROTECT_LOCK];
                stop_sw <= wbyte[`BIT_STOP_REQ];
            end
        end
    end

    // outputs registered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hv_enable <= 1'b0;
            array_read_block <= 1'b0;
            erase_mode <= 1'b0;
            erase_extent <= 2'h0;
            prog_addr <= 16'h0000;
            prog_data <= 16'h0000;
            prog_is_word <= 1'b0;
            prog_go <= 1'b0;
        end else begin
            hv_enable <= next_ctrl.hv_apply && !stopped;
            array_read_block <= next_ctrl.latch_arm;
            erase_mode <= next_ctrl.wipe_config;
            erase_extent <= next_ctrl.wipe_config ? extent_code : 2'h0;
            prog_addr <= lat.addr;
            prog_data <= lat.data;
            prog_is_word <= lat.is_word;
            prog_go <= ctrl.hv_apply && !stopped && op_allowed;
        end
    end
endmodule : eeprom_program_erase_ctrl

/* eeprom_ctrl_consts.svh */
`ifndef EEPROM_CTRL_CONSTS_SVH
`define EEPROM_CTRL_CONSTS_SVH

// register byte addresses and field positions
`define PROG_CTRL_ADDR 16'h00f3
`define PROG_CTRL_RESET 8'h00
`define GUARD_ADDR 16'h00f1
`define GUARD_RESET 8'h00
`define MODCFG_ADDR 16'h00f0
`define MODCFG_RESET 8'h00
`define STATUS_ADDR 16'h00f4
`define BIT_WIPE_GUARD 7
`define BIT_SINGLE_LOC 4
`define BIT_PAGE32 3
`define BIT_WIPE_CFG 2
`define BIT_LATCH_ARM 1
`define BIT_HV_APPLY 0
`define BIT_PROTECT_LOCK 1
`define BIT_STOP_REQ 0
`define CTRL_WRITABLE_MASK 8'h9f
// array window and block map
`define ARRAY_BASE 16'h0d00
`define ARRAY_LAST 16'h0fff
`define BLK3_BASE 16'h0e00
`define BLK2_BASE 16'h0f00
`define BLK1_BASE 16'h0f80
`define BLK0_BASE 16'h0fc0
`define GUARD_WIDTH 5

`endif

/* eeprom_ctrl_pkg.sv */
package eeprom_ctrl_pkg;

    typedef enum logic [1:0] {
        extent_bulk,
        extent_row,
        extent_single
    } erase_extent_e;

    typedef struct packed {
        logic whole_wipe_guard;
        logic single_loc_sel;
        logic page32_sel;
        logic wipe_config;
        logic latch_arm;
        logic hv_apply;
    } prog_ctrl_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic is_word;
        logic valid;
    } latch_s;

endpackage : eeprom_ctrl_pkg

/* guard_decode.sv */
`timescale 1ns/1ps
`include "eeprom_ctrl_consts.svh"

module guard_decode (
    input wire logic [15:0] addr,
    input wire logic [`GUARD_WIDTH-1:0] block_guard,
    output logic blocked
);
    wire in_blk4 = addr < `BLK3_BASE;
    wire in_blk3 = (addr >= `BLK3_BASE) && (addr < `BLK2_BASE);
    wire in_blk2 = (addr >= `BLK2_BASE) && (addr < `BLK1_BASE);
    wire in_blk1 = (addr >= `BLK1_BASE) && (addr < `BLK0_BASE);
    wire in_blk0 = addr >= `BLK0_BASE;
    wire [`GUARD_WIDTH-1:0] hit = {in_blk4, in_blk3, in_blk2, in_blk1, in_blk0};

    assign blocked = |(hit & block_guard);
endmodule : guard_decode

/* stop_sync.sv */
`timescale 1ns/1ps

module stop_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic async_in,
    output logic level
);
    logic [2:0] stage;

    // change taken only once the last two stages agree
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else begin
            stage <= {stage[1:0], async_in};
            if (stage[2] == stage[1]) begin
                level <= stage[2];
            end
        end
    end
endmodule : stop_sync

/* eeprom_ctrl_props.sv */
`timescale 1ns/1ps

module eeprom_ctrl_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic hv_enable,
    input wire logic array_read_block,
    input wire logic erase_mode,
    input wire logic [1:0] erase_extent,
    input wire logic [15:0] prog_addr,
    input wire logic [15:0] prog_data,
    input wire logic prog_go
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_ack_once;
        s_req |=> s_answer;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_arm_by_write;
        $rose(array_read_block) |-> wb_ack_o;
    endproperty
    a_arm_by_write: assert property (p_arm_by_write) else $error("arm outside a write");
    property p_hv_needs_arm;
        hv_enable |-> array_read_block;
    endproperty
    a_hv_needs_arm: assert property (p_hv_needs_arm) else $error("voltage without arm");
    property p_frozen;
        $past(hv_enable) && hv_enable |-> $stable(erase_mode) && $stable(erase_extent);
    endproperty
    a_frozen: assert property (p_frozen) else $error("fields moved under voltage");
    property p_latch_frozen;
        $past(prog_go) && prog_go |-> $stable(prog_addr) && $stable(prog_data);
    endproperty
    a_latch_frozen: assert property (p_latch_frozen) else $error("latch moved");
    property p_go_armed;
        prog_go |-> array_read_block;
    endproperty
    a_go_armed: assert property (p_go_armed) else $error("go without arm");
    property p_extent_idle;
        !erase_mode |-> erase_extent == 2'h0;
    endproperty
    a_extent_idle: assert property (p_extent_idle) else $error("extent outside erase");
endmodule : eeprom_ctrl_props

bind eeprom_program_erase_ctrl eeprom_ctrl_props u_props (.core_clk(core_clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .hv_enable(hv_enable),
    .array_read_block(array_read_block), .erase_mode(erase_mode), .erase_extent(erase_extent),
    .prog_addr(prog_addr), .prog_data(prog_data), .prog_go(prog_go));

/* eeprom_program_erase_ctrl_bench.sv */
`timescale 1ns/1ps

module eeprom_program_erase_ctrl_bench;
    logic core_clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, stop = 1'b0;
    logic [15:0] adr = 16'h0000, dat = 16'h0000, q, wb_dat_o, prog_addr, prog_data;
    logic [1:0] sel = 2'h0, erase_extent;
    logic wb_ack_o, hv_enable, array_read_block, erase_mode, prog_is_word, prog_go;
    int err_count = 0, compares = 0;

    always #50 core_clk = ~core_clk;

    eeprom_program_erase_ctrl dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_req_pin(stop), .hv_enable(hv_enable),
        .array_read_block(array_read_block), .erase_mode(erase_mode),
        .erase_extent(erase_extent), .prog_addr(prog_addr), .prog_data(prog_data),
        .prog_is_word(prog_is_word), .prog_go(prog_go));

    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
        input logic [1:0] s);
        @(posedge core_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : bus

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic ctl(input logic [7:0] v);
        bus(1'b1, 16'h00f3, {8'h00, v}, 2'h1);
    endtask : ctl

    // arm, latch one word, request voltage; prog_go settles one edge after hv_enable
    task automatic pg(input logic [15:0] a);
        ctl(8'h02);
        bus(1'b1, a, 16'ha55a, 2'h3);
        ctl(8'h03);
        @(posedge core_clk);
    endtask : pg

    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    initial begin
        #200us;
        err_count++;
        results();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        bus(1'b0, 16'h00f3, 16'h0000, 2'h1); chk(q, 16'h0000);
        ctl(8'h03); chk(hv_enable, 1'b0); chk(array_read_block, 1'b1);
        bus(1'b0, 16'h00f3, 16'h0000, 2'h1); chk(q, 16'h0002);
        for (int e = 0; e < 4; e++) begin
            ctl({3'h0, e[1:0], 3'h4}); chk(erase_extent, e[1] ? 2'h2 : {1'b0, e[0]});
            ctl({3'h0, e[1:0], 3'h6}); chk(erase_extent, e[1] ? 2'h2 : {1'b0, e[0]});
        end
        ctl(8'h18); chk(erase_extent, 2'h0); chk(erase_mode, 1'b0);
        bus(1'b0, 16'h0100, 16'h0000, 2'h1); chk(q, 16'h0000);
        pg(16'h0d02); chk(prog_go, 1'b1); chk(hv_enable, 1'b1);
        chk(prog_addr, 16'h0d02); chk(prog_data, 16'ha55a); chk(prog_is_word, 1'b1);
        ctl(8'h9d); bus(1'b0, 16'h00f3, 16'h0000, 2'h1); chk(q, 16'h0003);
        bus(1'b1, 16'h0d04, 16'h1111, 2'h3); chk(prog_data, 16'ha55a);
        stop <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(hv_enable, 1'b0);
        stop <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(hv_enable, 1'b1);
        ctl(8'h02); chk(hv_enable, 1'b0); chk(array_read_block, 1'b1);
        ctl(8'h00); chk(array_read_block, 1'b0);
        ctl(8'h80); ctl(8'h86); bus(1'b1, 16'h0d00, 16'h5a5a, 2'h3);
        ctl(8'h87); @(posedge core_clk); chk(prog_go, 1'b0);
        ctl(8'h86); ctl(8'h00);
        ctl(8'h06); bus(1'b1, 16'h0d00, 16'h5a5a, 2'h3); ctl(8'h07);
        @(posedge core_clk); chk(prog_go, 1'b1); chk(erase_mode, 1'b1);
        ctl(8'h06); ctl(8'h00);
        bus(1'b1, 16'h00f0, 16'h0200, 2'h2); ctl(8'h80);
        bus(1'b0, 16'h00f3, 16'h0000, 2'h1); chk(q, 16'h0000);
        bus(1'b1, 16'h00f0, 16'h0000, 2'h2);
        bus(1'b1, 16'h00f1, 16'h0001, 2'h1);
        pg(16'h0fc0); chk(prog_go, 1'b0);
        ctl(8'h00); bus(1'b1, 16'h00f1, 16'h0000, 2'h1);
        results();
    end
endmodule : eeprom_program_erase_ctrl_bench
